// ===== hdl/erfs_pkg.sv
// Purpose: Shared constants, types and CRC step for the receive filter
// Assumes: 32-bit APB register words at byte offsets below
// Notes: Frame byte counts include destination address through FCS
package erfs_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFF_MODE = 8'h00;
	localparam logic [7:0] OFF_FEATURE = 8'h04;
	localparam logic [7:0] OFF_FIFO_THR = 8'h08;
	localparam logic [7:0] OFF_TEST = 8'h0c;
	localparam logic [7:0] OFF_DUPLEX = 8'h10;
	localparam logic [7:0] OFF_STYLE = 8'h14;
	localparam logic [7:0] OFF_STA_LO = 8'h18;
	localparam logic [7:0] OFF_STA_HI = 8'h1c;
	localparam logic [7:0] OFF_HASH_LO = 8'h20;
	localparam logic [7:0] OFF_HASH_HI = 8'h24;
	localparam logic [7:0] OFF_DESC = 8'h28;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int MODE_DUA_BIT = 13;
	localparam int MODE_DBA_BIT = 14;
	localparam int MODE_PROMISCUOUS_ENABLE_BIT = 15;
	localparam int FEAT_STRIP_BIT = 0;
	localparam int FEAT_EXTERNAL_ADDRESS_DETECT_PORT_BIT = 1;
	localparam int THR_WM_LSB = 12;
	localparam int TEST_RPA_BIT = 3;
	localparam int DUP_FD_BIT = 0;
	localparam int DUP_FULL_DUPLEX_RUNT_ACCEPT_DISABLE_BIT = 2;
	localparam int DESC_ERR_BIT = 30;
	localparam int DESC_CRC_BIT = 27;
	localparam int DESC_PAM_BIT = 22;
	localparam int DESC_HASH_MATCH_FLAG_BIT = 21;
	localparam int DESC_BAM_BIT = 20;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [1:0] WM_RST = 2'h1;
	localparam logic [7:0] STYLE_RST = 8'h00;

	// ---------------------------------------------------------------
	// Frame constants
	// ---------------------------------------------------------------
	localparam logic [3:0] SFD_NIBBLE = 4'hd;
	localparam logic [10:0] MIN_FRAME = 11'h040;
	localparam logic [10:0] SLOT_BYTES = 11'h040;
	localparam logic [10:0] EXTERNAL_ADDRESS_DETECT_PORT_WINDOW = 11'h040;
	localparam logic [10:0] HDR_BYTES = 11'h00e;
	localparam logic [10:0] DA_LAST = 11'h005;
	localparam logic [10:0] LEN_HI_IDX = 11'h00c;
	localparam logic [10:0] LEN_LO_IDX = 11'h00d;
	localparam logic [10:0] FCS_BYTES = 11'h004;
	localparam logic [15:0] LEN_STRIP = 16'h002e;
	localparam logic [7:0] STYLE_32A = 8'h02;
	localparam logic [7:0] STYLE_32B = 8'h03;
	localparam logic [10:0] WM_00 = 11'h010;
	localparam logic [10:0] WM_01 = 11'h040;
	localparam logic [10:0] WM_10 = 11'h080;
	localparam logic [10:0] WM_11 = 11'h100;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

	typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_DATA, ST_FLUSH, ST_DONE} erfs_state_t;

	// One byte of the reflected CRC-32, least significant bit first
	function automatic logic [31:0] erfs_crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction : erfs_crc_byte

endpackage : erfs_pkg

// ===== hdl/erfs_rx_filter.sv
// Purpose: Receive classification, address filter, pad strip and FCS check
// Assumes: Nibble link sampled on CLK; receive FIFO deletes frames not kept
// Notes: Data bytes leave four bytes late so that FCS can be dropped
//
// Overview of operation
// R1: First DA bit 0 means unicast, 1 multicast; all-ones DA is broadcast.
// R2: Unicast accepted only on exact match with the 6-byte station address.
// R3: First received DA byte matches address bits 7:0, sixth bits 47:40.
// R4: Disable-unicast bit rejects unicast frames unless promiscuous.
// R5: Multicast passes through hash filter; all-zero filter passes only broadcast.
// R6: Broadcast accepted unless disable-broadcast set and hash filter misses.
// R7: Promiscuous accepts every frame, overriding both disable bits.
// R8: Descriptor bits 22, 21, 20 record station, hash, broadcast match.
// R9: Match flags appear only for descriptor style 2 or 3.
// R10: Broadcast sets only broadcast flag, or hash flag when disable-broadcast set.
// R11: External detect: accept unmatched frame unless reject pin low in 64 bytes.
// R12: DMA request starts at receive watermark; watermark resets to 64 bytes.
// R13: Pad strip enabled strips frames with length below 46, others unchanged.
// R14: Pad stripped before FIFO; stripped frames also lose their FCS.
// R15: FCS checked over whole stream including pad; mismatch flagged in descriptor.
// R16: Frames colliding within first 512 bit times are deleted automatically; the code only does so in half duplex and ignores COL in full duplex.
// R17: Runts deleted in half duplex without runt accept, or full duplex with disable.
// R18: Runt deletion applies whether frame is alone or queued behind others.
// R19: Full duplex requests DMA at watermark or on a complete valid frame.
// R20: Receive FCS is the IEEE 802.3 CRC-32 over DA through pad and FCS.
`timescale 1ns/1ps
module erfs_rx_filter (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// APB register slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Link from the transceiver
	input wire logic RX_CLK,
	input wire logic RX_DV,
	input wire logic [3:0] RXD,
	input wire logic COL,
	input wire logic EAR_N,
	// Receive FIFO side
	output logic OUT_VALID,
	output logic [7:0] OUT_DATA,
	output logic FRAME_DONE,
	output logic FRAME_KEEP,
	output logic [31:0] DESC_WORD,
	output logic DMA_REQ
);

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic promiscuous_enable, dba, dua, strip_en, external_address_detect_port_en, runt_accept, fd, full_duplex_runt_accept_disable;
	logic next_promiscuous_enable, next_dba, next_dua, next_strip_en, next_external_address_detect_port_en;
	logic next_rpa, next_fd, next_full_duplex_runt_accept_disable;
	logic [1:0] wm_sel, next_wm_sel;
	logic [7:0] style, next_style;
	logic [47:0] sta, next_sta;
	logic [63:0] hash, next_hash;
	logic pready, next_pready, pslverr, next_pslverr;
	logic [31:0] prdata, next_prdata, rd;
	logic err;

	// ---------------------------------------------------------------
	// Receive state
	// ---------------------------------------------------------------
	logic [7:0] s1, s2;
	logic rxc_d;
	erfs_pkg::erfs_state_t st, next_st;
	logic half, next_half;
	logic [3:0] lo, next_lo;
	logic [10:0] cnt, next_cnt;
	logic [3:0][7:0] dly, next_dly;
	logic [31:0] crc, next_crc;
	logic [47:0] da, next_da;
	logic [15:0] len, next_len;
	logic strip, next_strip, dec, next_dec;
	logic station_match_flag, hash_match_flag, broadcast_match_flag, next_pam, next_hash_match_flag, next_bam;
	logic coll, next_coll, ear_rej, next_ear_rej;
	logic [2:0] fk, next_fk;
	logic ov, next_ov, done, next_done, keep, next_keep, dma, next_dma;
	logic [7:0] od, next_od;
	logic [31:0] desc, next_desc;

	// Synchronised link signals
	logic rise, dv, col_s, ear_s;
	logic [3:0] nib;
	assign rise = s2[7] & ~rxc_d;
	assign dv = s2[6];
	assign col_s = s2[5];
	assign ear_s = s2[4];
	assign nib = s2[3:0];

	// ---------------------------------------------------------------
	// APB decode and register writes
	// ---------------------------------------------------------------
	always_comb begin
		next_promiscuous_enable = promiscuous_enable;
		next_dba = dba;
		next_dua = dua;
		next_strip_en = strip_en;
		next_external_address_detect_port_en = external_address_detect_port_en;
		next_rpa = runt_accept;
		next_fd = fd;
		next_full_duplex_runt_accept_disable = full_duplex_runt_accept_disable;
		next_wm_sel = wm_sel;
		next_style = style;
		next_sta = sta;
		next_hash = hash;
		next_prdata = prdata;
		next_pslverr = 1'b0;
		rd = 32'h00000000;
		err = (PADDR[1:0] != 2'h0);
		// Read mux
		case (PADDR)
			erfs_pkg::OFF_MODE: begin
				rd[erfs_pkg::MODE_DUA_BIT] = dua;
				rd[erfs_pkg::MODE_DBA_BIT] = dba;
				rd[erfs_pkg::MODE_PROMISCUOUS_ENABLE_BIT] = promiscuous_enable;
			end
			erfs_pkg::OFF_FEATURE: begin
				rd[erfs_pkg::FEAT_STRIP_BIT] = strip_en;
				rd[erfs_pkg::FEAT_EXTERNAL_ADDRESS_DETECT_PORT_BIT] = external_address_detect_port_en;
			end
			erfs_pkg::OFF_FIFO_THR: rd[erfs_pkg::THR_WM_LSB +: 2] = wm_sel;
			erfs_pkg::OFF_TEST: rd[erfs_pkg::TEST_RPA_BIT] = runt_accept;
			erfs_pkg::OFF_DUPLEX: begin
				rd[erfs_pkg::DUP_FD_BIT] = fd;
				rd[erfs_pkg::DUP_FULL_DUPLEX_RUNT_ACCEPT_DISABLE_BIT] = full_duplex_runt_accept_disable;
			end
			erfs_pkg::OFF_STYLE: rd[7:0] = style;
			erfs_pkg::OFF_STA_LO: rd = sta[31:0];
			erfs_pkg::OFF_STA_HI: rd[15:0] = sta[47:32];
			erfs_pkg::OFF_HASH_LO: rd = hash[31:0];
			erfs_pkg::OFF_HASH_HI: rd = hash[63:32];
			erfs_pkg::OFF_DESC: rd = desc;
			default: err = 1'b1;
		endcase
		// One wait state, answer registered
		next_pready = PSEL & PENABLE & ~pready;
		if (PSEL && PENABLE && !pready) begin
			next_prdata = PWRITE ? 32'h00000000 : rd;
			next_pslverr = err;
		end
		// Write takes effect at the completing edge
		if (PSEL && PENABLE && pready && PWRITE && !pslverr) begin
			case (PADDR)
				erfs_pkg::OFF_MODE: begin
					next_dua = PWDATA[erfs_pkg::MODE_DUA_BIT];
					next_dba = PWDATA[erfs_pkg::MODE_DBA_BIT];
					next_promiscuous_enable = PWDATA[erfs_pkg::MODE_PROMISCUOUS_ENABLE_BIT];
				end
				erfs_pkg::OFF_FEATURE: begin
					next_strip_en = PWDATA[erfs_pkg::FEAT_STRIP_BIT];
					next_external_address_detect_port_en = PWDATA[erfs_pkg::FEAT_EXTERNAL_ADDRESS_DETECT_PORT_BIT];
				end
				erfs_pkg::OFF_FIFO_THR: next_wm_sel = PWDATA[erfs_pkg::THR_WM_LSB +: 2];
				erfs_pkg::OFF_TEST: next_rpa = PWDATA[erfs_pkg::TEST_RPA_BIT];
				erfs_pkg::OFF_DUPLEX: begin
					next_fd = PWDATA[erfs_pkg::DUP_FD_BIT];
					next_full_duplex_runt_accept_disable = PWDATA[erfs_pkg::DUP_FULL_DUPLEX_RUNT_ACCEPT_DISABLE_BIT];
				end
				erfs_pkg::OFF_STYLE: next_style = PWDATA[7:0];
				erfs_pkg::OFF_STA_LO: next_sta[31:0] = PWDATA;
				erfs_pkg::OFF_STA_HI: next_sta[47:32] = PWDATA[15:0];
				erfs_pkg::OFF_HASH_LO: next_hash[31:0] = PWDATA;
				erfs_pkg::OFF_HASH_HI: next_hash[63:32] = PWDATA;
				default: next_promiscuous_enable = promiscuous_enable;
			endcase
		end
	end

	// Register bank flops
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			promiscuous_enable <= 1'b0;
			dba <= 1'b0;
			dua <= 1'b0;
			strip_en <= 1'b0;
			external_address_detect_port_en <= 1'b0;
			runt_accept <= 1'b0;
			fd <= 1'b0;
			full_duplex_runt_accept_disable <= 1'b0;
			wm_sel <= erfs_pkg::WM_RST; // [R12]
			style <= erfs_pkg::STYLE_RST;
			sta <= 48'h000000000000;
			hash <= 64'h0000000000000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			promiscuous_enable <= next_promiscuous_enable;
			dba <= next_dba;
			dua <= next_dua;
			strip_en <= next_strip_en;
			external_address_detect_port_en <= next_external_address_detect_port_en;
			runt_accept <= next_rpa;
			fd <= next_fd;
			full_duplex_runt_accept_disable <= next_full_duplex_runt_accept_disable;
			wm_sel <= next_wm_sel;
			style <= next_style;
			sta <= next_sta;
			hash <= next_hash;
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
		end
	end

	// ---------------------------------------------------------------
	// Link synchroniser and receive engine
	// ---------------------------------------------------------------
	logic [7:0] b;
	logic [47:0] da_full;
	logic [10:0] j, wm, limit;
	logic [2:0] held;
	logic [1:0] di;
	logic bc, mc, sm, hh, accept, runt, flags_on;

	always_comb begin
		next_st = st;
		next_half = half;
		next_lo = lo;
		next_cnt = cnt;
		next_dly = dly;
		next_crc = crc;
		next_da = da;
		next_len = len;
		next_strip = strip;
		next_dec = dec;
		next_pam = station_match_flag;
		next_hash_match_flag = hash_match_flag;
		next_bam = broadcast_match_flag;
		next_coll = coll;
		next_ear_rej = ear_rej;
		next_fk = fk;
		next_ov = 1'b0;
		next_od = od;
		next_done = 1'b0;
		next_keep = keep;
		next_desc = desc;
		next_dma = 1'b0;
		b = {nib, lo};
		da_full = {b, da[47:8]};
		bc = 1'b0;
		mc = 1'b0;
		sm = 1'b0;
		hh = 1'b0;
		j = 11'h000;
		di = 2'h0;
		held = (cnt >= erfs_pkg::FCS_BYTES) ? 3'h4 : cnt[2:0];
		limit = erfs_pkg::HDR_BYTES + len[10:0];
		// Watermark select
		case (wm_sel)
			2'h0: wm = erfs_pkg::WM_00;
			2'h1: wm = erfs_pkg::WM_01;
			2'h2: wm = erfs_pkg::WM_10;
			default: wm = erfs_pkg::WM_11;
		endcase
		accept = station_match_flag | hash_match_flag | broadcast_match_flag | promiscuous_enable | (external_address_detect_port_en & ~ear_rej); // [R7] [R11]
		runt = (cnt < erfs_pkg::MIN_FRAME) & ((~fd & ~runt_accept) | (fd & full_duplex_runt_accept_disable)); // [R17] [R18]
		flags_on = (style == erfs_pkg::STYLE_32A) | (style == erfs_pkg::STYLE_32B); // [R9]
		case (st)
			erfs_pkg::ST_IDLE: begin
				if (rise && dv) begin
					next_st = erfs_pkg::ST_PRE;
					next_cnt = 11'h000;
					next_half = 1'b0;
					next_crc = erfs_pkg::CRC_INIT;
					next_strip = 1'b0;
					next_dec = 1'b0;
					next_pam = 1'b0;
					next_hash_match_flag = 1'b0;
					next_bam = 1'b0;
					next_coll = 1'b0;
					next_ear_rej = 1'b0;
					next_len = 16'hffff;
				end
			end
			erfs_pkg::ST_PRE: begin
				if (rise && !dv) begin
					next_st = erfs_pkg::ST_IDLE;
				end else if (rise && nib == erfs_pkg::SFD_NIBBLE) begin
					next_st = erfs_pkg::ST_DATA;
				end
			end
			erfs_pkg::ST_DATA: begin
				// Early external reject and early collision
				if (!ear_s && external_address_detect_port_en && !promiscuous_enable && cnt < erfs_pkg::EXTERNAL_ADDRESS_DETECT_PORT_WINDOW) begin
					next_ear_rej = 1'b1; // [R11]
				end
				if (col_s && !fd && cnt < erfs_pkg::SLOT_BYTES) begin
					next_coll = 1'b1; // [R16]
				end
				// DMA request once watermark reached on a passing frame
				next_dma = dec & accept & ~coll & (cnt >= wm)
					& (fd | runt_accept | cnt >= erfs_pkg::MIN_FRAME); // [R12] [R16] [R19]
				if (rise && !dv) begin
					next_st = erfs_pkg::ST_FLUSH;
					next_fk = 3'h0;
				end else if (rise && !half) begin
					next_lo = nib;
					next_half = 1'b1;
				end else if (rise) begin
					next_half = 1'b0;
					next_crc = erfs_pkg::erfs_crc_byte(crc, b); // [R20]
					next_dly = {dly[2:0], b};
					next_cnt = cnt + 11'h001;
					if (cnt <= erfs_pkg::DA_LAST) begin
						next_da = da_full; // [R3]
					end
					if (cnt == erfs_pkg::DA_LAST) begin
						mc = da_full[0]; // [R1]
						bc = &da_full; // [R1]
						sm = ~mc & (da_full == sta); // [R2] [R3]
						hh = hash[next_crc[5:0]]; // [R5]
						next_dec = 1'b1;
						next_pam = sm & ~dua; // [R4] [R8]
						next_hash_match_flag = mc & hh & (~bc | dba); // [R5] [R6] [R10]
						next_bam = bc & ~dba; // [R6] [R10]
					end
					if (cnt == erfs_pkg::LEN_HI_IDX) begin
						next_len[15:8] = b;
					end
					if (cnt == erfs_pkg::LEN_LO_IDX) begin
						next_len[7:0] = b;
						next_strip = strip_en & ({len[15:8], b} < erfs_pkg::LEN_STRIP); // [R13]
					end
					// Release the byte four behind, dropping pad when stripping
					j = cnt - erfs_pkg::FCS_BYTES;
					if (cnt >= erfs_pkg::FCS_BYTES && (!strip || j < limit)) begin
						next_ov = 1'b1; // [R14]
						next_od = dly[3];
					end
				end
			end
			erfs_pkg::ST_FLUSH: begin
				// Held tail bytes: FCS kept only when not stripped
				j = cnt - {8'h00, held} + {8'h00, fk};
				di = 2'(held - 3'h1 - fk);
				if (held == 3'h0 || fk == held - 3'h1) begin
					next_st = erfs_pkg::ST_DONE;
				end
				if (held != 3'h0 && (!strip || j < limit)) begin
					next_ov = 1'b1; // [R14]
					next_od = dly[di];
				end
				next_fk = fk + 3'h1;
			end
			erfs_pkg::ST_DONE: begin
				// Frame verdict and descriptor word
				next_st = erfs_pkg::ST_IDLE;
				next_done = 1'b1;
				next_keep = accept & ~coll & ~runt; // [R16] [R17]
				next_dma = accept & ~coll & ~runt; // [R19]
				next_desc = 32'h00000000;
				next_desc[10:0] = cnt;
				next_desc[erfs_pkg::DESC_ERR_BIT] = (crc != erfs_pkg::CRC_RESIDUE); // [R15]
				next_desc[erfs_pkg::DESC_CRC_BIT] = (crc != erfs_pkg::CRC_RESIDUE); // [R15]
				next_desc[erfs_pkg::DESC_PAM_BIT] = station_match_flag & flags_on; // [R8] [R9]
				next_desc[erfs_pkg::DESC_HASH_MATCH_FLAG_BIT] = hash_match_flag & flags_on; // [R8] [R9]
				next_desc[erfs_pkg::DESC_BAM_BIT] = broadcast_match_flag & flags_on; // [R8] [R9]
			end
			default: next_st = erfs_pkg::ST_IDLE;
		endcase
	end

	// Receive engine flops
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s1 <= 8'h00;
			s2 <= 8'h00;
			rxc_d <= 1'b0;
			st <= erfs_pkg::ST_IDLE;
			half <= 1'b0;
			lo <= 4'h0;
			cnt <= 11'h000;
			dly <= 32'h00000000;
			crc <= erfs_pkg::CRC_INIT;
			da <= 48'h000000000000;
			len <= 16'hffff;
			strip <= 1'b0;
			dec <= 1'b0;
			station_match_flag <= 1'b0;
			hash_match_flag <= 1'b0;
			broadcast_match_flag <= 1'b0;
			coll <= 1'b0;
			ear_rej <= 1'b0;
			fk <= 3'h0;
			ov <= 1'b0;
			od <= 8'h00;
			done <= 1'b0;
			keep <= 1'b0;
			desc <= 32'h00000000;
			dma <= 1'b0;
		end else begin
			s1 <= {RX_CLK, RX_DV, COL, EAR_N, RXD};
			s2 <= s1;
			rxc_d <= s2[7];
			st <= next_st;
			half <= next_half;
			lo <= next_lo;
			cnt <= next_cnt;
			dly <= next_dly;
			crc <= next_crc;
			da <= next_da;
			len <= next_len;
			strip <= next_strip;
			dec <= next_dec;
			station_match_flag <= next_pam;
			hash_match_flag <= next_hash_match_flag;
			broadcast_match_flag <= next_bam;
			coll <= next_coll;
			ear_rej <= next_ear_rej;
			fk <= next_fk;
			ov <= next_ov;
			od <= next_od;
			done <= next_done;
			keep <= next_keep;
			desc <= next_desc;
			dma <= next_dma;
		end
	end

	// Outputs straight from flops
	assign PRDATA = prdata;
	assign PREADY = pready;
	assign PSLVERR = pslverr;
	assign OUT_VALID = ov;
	assign OUT_DATA = od;
	assign FRAME_DONE = done;
	assign FRAME_KEEP = keep;
	assign DESC_WORD = desc;
	assign DMA_REQ = dma;

endmodule : erfs_rx_filter

// ===== sim/erfs_rx_filter_asserts.sv
// Purpose: Port-level checks of the receive filter
// Assumes: One wait state APB, registered frame results
// Notes: Bound to every instance of the filter
`timescale 1ns/1ps
module erfs_rx_filter_asserts (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Frame results
	input wire logic FRAME_DONE,
	input wire logic FRAME_KEEP,
	input wire logic [31:0] DESC_WORD,
	input wire logic DMA_REQ
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	// --------------------------------
	// Bus answer
	// --------------------------------
	sequence s_wait_ready;
		!PREADY ##1 PREADY ##1 !PREADY;
	endsequence
	a_ready_wait: assert property ($rose(PENABLE) |-> s_wait_ready)
		else $error("ready not one wait state pulse");
	a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE))
		else $error("ready outside access phase");
	a_err_unmapped: assert property (PREADY && (PADDR[1:0] != 2'h0 || PADDR > 8'h28)
		|-> PSLVERR && PRDATA == 32'h0) else $error("unmapped access not refused");
	a_write_rdata: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
		else $error("read data on write");

	// --------------------------------
	// Frame results
	// --------------------------------
	a_done_pulse: assert property (FRAME_DONE |=> !FRAME_DONE)
		else $error("frame done wider than one cycle");
	a_result_hold: assert property (!FRAME_DONE |-> $stable(FRAME_KEEP) && $stable(DESC_WORD))
		else $error("result changed without frame done");
	a_flags_single: assert property ($onehot0(DESC_WORD[22:20]))
		else $error("several match flags set");
	a_kept_dma: assert property (FRAME_DONE && FRAME_KEEP |-> DMA_REQ)
		else $error("no transfer request for kept frame");
	a_fcs_err: assert property (DESC_WORD[27] |-> DESC_WORD[30])
		else $error("fcs error without error bit");
endmodule : erfs_rx_filter_asserts

bind erfs_rx_filter erfs_rx_filter_asserts i_erfs_rx_filter_asserts (.CLK, .RESETN, .PSEL,
	.PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY, .PSLVERR, .FRAME_DONE, .FRAME_KEEP,
	.DESC_WORD, .DMA_REQ);

// ===== sim/erfs_phy_model.sv
// Purpose: Nibble transceiver that sends whole frames
// Assumes: Link clock of 80 ns, parked outside frames
// Notes: Data changes half a link period before each rising edge
`timescale 1ns/1ps
module erfs_phy_model (
	// Link outputs
	output logic RX_CLK,
	output logic RX_DV,
	output logic [3:0] RXD,
	output logic COL,
	output logic EAR_N
);
	// Idle link
	initial begin
		RX_CLK = 1'b0;
		RX_DV = 1'b0;
		RXD = 4'ha;
		COL = 1'b0;
		EAR_N = 1'b1;
	end

	// Preamble, delimiter, frame nibbles low first, then two idle edges
	task send(input logic [7:0] f[$], input int cat, input logic rej);
		int i;
		for (i = 0; i < 16 + 2 * f.size(); i++) begin
			RX_DV = 1'b1;
			RXD = (i < 15) ? 4'h5 : (i == 15) ? 4'hd :
				(i[0] ? f[(i - 16) / 2][7:4] : f[(i - 16) / 2][3:0]);
			COL = (cat >= 0) && (i >= 16 + 2 * cat);
			EAR_N = !(rej && i >= 40);
			#40 RX_CLK = 1'b1;
			#40 RX_CLK = 1'b0;
		end
		RX_DV = 1'b0;
		COL = 1'b0;
		EAR_N = 1'b1;
		RXD = ~RXD;
		repeat (2) begin
			#40 RX_CLK = 1'b1;
			#40 RX_CLK = 1'b0;
		end
	endtask : send
endmodule : erfs_phy_model

// ===== sim/erfs_rx_filter_test.sv
// Purpose: Self-checking bench for the receive filter
// Assumes: Transceiver model drives the link side
// Notes: Hash filter is all zeros or all ones
`timescale 1ns/1ps
module erfs_rx_filter_test;
	// Design signals
	logic CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RX_CLK, RX_DV, COL, EAR_N;
	logic OUT_VALID, FRAME_DONE, FRAME_KEEP, DMA_REQ;
	logic [7:0] PADDR, OUT_DATA;
	logic [31:0] PWDATA, PRDATA, DESC_WORD;
	logic [3:0] RXD;
	logic [7:0] f[$];
	logic [7:0] got[$];
	logic [47:0] sta;
	int err_total, n_tests, dn, dq, seed;

	erfs_rx_filter i_erfs_rx_filter (.CLK, .RESETN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
		.PRDATA, .PREADY, .PSLVERR, .RX_CLK, .RX_DV, .RXD, .COL, .EAR_N, .OUT_VALID,
		.OUT_DATA, .FRAME_DONE, .FRAME_KEEP, .DESC_WORD, .DMA_REQ);
	erfs_phy_model i_erfs_phy_model (.RX_CLK, .RX_DV, .RXD, .COL, .EAR_N);

	// 250 MHz clock
	initial CLK = 1'b0;
	always #2 CLK = ~CLK;

	// Byte and frame-end capture
	always @(posedge CLK) begin
		if (OUT_VALID === 1'b1) got.push_back(OUT_DATA);
		if (DMA_REQ === 1'b1) dq++;
		if (FRAME_DONE === 1'b1) dn++;
	end

	// --------------------------------
	// Tasks
	// --------------------------------
	task end_sim;
		$display("Counts: %0d mismatches in %0d compares", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			err_total++;
			$display("BAD at %0t got %h exp %h", $time, g, x);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		// Ready, data and error taken at the completing rising edge
		for (k = 0; k < 20; k++) begin
			@(posedge CLK);
			if (PREADY === 1'b1) break;
		end
		if (k == 20) begin
			err_total++;
			end_sim;
		end
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	function automatic logic [31:0] crc(input logic [7:0] q[$]);
		logic [31:0] c;
		c = 32'hffffffff;
		foreach (q[j]) for (int b = 0; b < 8; b++) c = (c[0] ^ q[j][b]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
		return ~c;
	endfunction : crc

	// cf: 0 strip, 1 ext detect, 2 reject, 3 runt accept, 4 fd, 5 fd runt drop, 6 style, 7 hash
	task run(input logic [15:0] md, input logic [7:0] cf, input logic [1:0] dt,
		input logic [15:0] ln, input int n, input logic bad, input int cat);
		logic [47:0] da;
		logic [31:0] fc;
		logic [2:0] fl;
		logic pass, keep;
		int d0, k, xo, tot;
		wr(erfs_pkg::OFF_MODE, {16'h0, md});
		wr(erfs_pkg::OFF_FEATURE, {30'h0, cf[1:0]});
		wr(erfs_pkg::OFF_TEST, {28'h0, cf[3], 3'h0});
		wr(erfs_pkg::OFF_DUPLEX, {29'h0, cf[5], 1'b0, cf[4]});
		wr(erfs_pkg::OFF_STYLE, cf[6] ? 32'h2 + 32'($random(seed) & 1) : 32'h0);
		wr(erfs_pkg::OFF_HASH_LO, {32{cf[7]}});
		wr(erfs_pkg::OFF_HASH_HI, {32{cf[7]}});
		da = dt == 0 ? sta : dt == 1 ? sta ^ 48'h100 : dt == 2 ? '1 : {$random(seed), 16'h1};
		f = {};
		for (k = 0; k < 6; k++) f.push_back(da[8 * k +: 8]);
		for (k = 0; k < 6; k++) f.push_back(8'($random(seed)));
		f.push_back(ln[15:8]);
		f.push_back(ln[7:0]);
		for (k = 0; k < n; k++) f.push_back(8'($random(seed)));
		fc = crc(f) ^ {31'h0, bad};
		for (k = 0; k < 4; k++) f.push_back(fc[8 * k +: 8]);
		d0 = dn;
		got = {};
		dq = 0;
		i_erfs_phy_model.send(f, cat, cf[2]);
		for (k = 0; k < 400 && dn == d0; k++) @(posedge CLK);
		if (dn == d0) begin
			err_total++;
			end_sim;
		end
		pass = 1'b0;
		fl = 3'h0;
		case (dt)
			0: begin
				pass = !md[13];
				fl = 3'h4;
			end
			2: begin
				pass = !md[14] || cf[7];
				fl = md[14] ? 3'h2 : 3'h1;
			end
			3: begin
				pass = cf[7];
				fl = 3'h2;
			end
		endcase
		if (cf[1] && !pass) begin
			pass = !cf[2];
			fl = 3'h0;
		end
		tot = 14 + n + 4;
		keep = (md[15] || pass) && !(tot < 64 && (cf[4] ? cf[5] : !cf[3])) && !(cat >= 0 && !cf[4]);
		xo = (cf[0] && ln < 46) ? 14 + ln : tot;
		if (!bad) chk(32'(FRAME_KEEP), 32'(keep));
		if (!bad) chk(32'(dq != 0), 32'(keep));
		chk(32'(DESC_WORD[27]), 32'(bad));
		if (keep && !md[15]) chk(32'(DESC_WORD[22:20]), 32'(cf[6] ? fl : 3'h0));
		if (xo == tot) chk(32'(DESC_WORD[10:0]), tot);
		if (cat < 0) begin
			chk(32'(got.size()), xo);
			foreach (got[j]) chk(32'(got[j]), 32'(f[j]));
		end
	endtask : run

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		logic [31:0] r;
		logic e;
		seed = 55758;
		err_total = 0;
		n_tests = 0;
		dn = 0;
		RESETN = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h0;
		PWDATA = 32'h0;
		repeat (12) @(posedge CLK);
		RESETN <= 1'b1;
		apb(1'b0, erfs_pkg::OFF_FIFO_THR, 32'h0, r, e);
		chk(32'(r[13:12]), 32'h1);
		apb(1'b0, erfs_pkg::OFF_MODE, 32'h0, r, e);
		chk(r, 32'h0);
		apb(1'b0, 8'h40, 32'h0, r, e);
		chk({r[30:0], e}, 32'h1);
		sta = 48'({$random(seed), $random(seed)}) & ~48'h1;
		wr(erfs_pkg::OFF_STA_LO, sta[31:0]);
		wr(erfs_pkg::OFF_STA_HI, {16'h0, sta[47:32]});
		apb(1'b0, erfs_pkg::OFF_STA_HI, 32'h0, r, e);
		chk(r, {16'h0, sta[47:32]});
		run(16'h0000, 8'h40, 0, 16'h0800, 46, 0, -1);
		run(16'h0000, 8'h40, 1, 16'h0800, 46, 0, -1);
		run(16'h2000, 8'h40, 0, 16'h0800, 46, 0, -1);
		run(16'ha000, 8'h40, 1, 16'h0800, 46, 0, -1);
		run(16'hc000, 8'h40, 2, 16'h0800, 46, 0, -1);
		run(16'h0000, 8'h40, 2, 16'h0800, 46, 0, -1);
		run(16'h4000, 8'h40, 2, 16'h0800, 46, 0, -1);
		run(16'h4000, 8'hc0, 2, 16'h0800, 46, 0, -1);
		run(16'h0000, 8'h40, 3, 16'h0800, 46, 0, -1);
		run(16'h0000, 8'hc0, 3, 16'h0800, 46, 0, -1);
		run(16'h0000, 8'h00, 0, 16'h0800, 46, 0, -1);
		run(16'h0000, 8'h40, 0, 16'h0800, 46, 1, -1);
		run(16'h0000, 8'h41, 0, 16'h0014, 46, 0, -1);
		run(16'h0000, 8'h41, 0, 16'h002e, 46, 0, -1);
		run(16'h0000, 8'h40, 0, 16'h0800, 45, 0, -1);
		run(16'h0000, 8'h48, 0, 16'h0800, 45, 0, -1);
		run(16'h0000, 8'h50, 0, 16'h0800, 45, 0, -1);
		run(16'h0000, 8'h70, 0, 16'h0800, 45, 0, -1);
		run(16'h0000, 8'h40, 0, 16'h0800, 46, 0, 20);
		run(16'h0000, 8'h42, 1, 16'h0800, 46, 0, -1);
		run(16'h0000, 8'h46, 1, 16'h0800, 46, 0, -1);
		repeat (4) run(16'($random(seed)) & 16'he000, 8'($random(seed)) & 8'hc0,
			2'($random(seed)), 16'h0800, 46, 0, -1);
		end_sim;
	end
endmodule : erfs_rx_filter_test
